// File: ccd_frame_readout_sequencer.sv
// timing controller driving a frame-transfer ccd through clearing, transfer and readout
module ccd_frame_readout_sequencer import ccd_readout_pkg::*; #(
   parameter int NCOLS = COLS,
   parameter int NLINES = LINES,
   parameter int DIV = PIX_DIV
) (
   input wire logic i_mclk, // 10 MHz system clock
   input wire logic i_resetn, // sync reset, active low
   input wire logic i_start, // frame request pulse
   input wire frame_cfg_t i_cfg, // frame settings, taken with i_start
   output gate_bus_t o_gates, // gate clocks and drain pulses
   output logic o_sample_reset, // strobe: sample reset level
   output logic o_sample_signal, // strobe: sample signal level
   output logic o_dark_ref, // current sample is dark reference
   output logic o_line_start, // pulse at start of a line readout
   output logic o_frame_done, // pulse at end of frame
   output logic o_busy, // sequence in progress
   output logic o_exposing // integration interval running
);
   localparam int NROWS = NLINES + ISO_LINES;
   localparam logic [9:0] COL_LAST = 10'(NCOLS - 1);
   localparam logic [9:0] DARK_L = 10'(DARK_COLS);
   localparam logic [8:0] ROW_LAST = 9'(NROWS - 1);
   localparam logic [8:0] ROW_END = 9'(NROWS);
   localparam logic [8:0] ISO_L = 9'(ISO_LINES);
   localparam logic [EXP_W-1:0] CLEAR_LAST = EXP_W'(CLEAR_CYC - 1);
   localparam logic [EXP_W-1:0] CLEAR_LEN = EXP_W'(CLEAR_CYC);

   generate
      if (NCOLS < DARK_COLS + 1 || NCOLS > 1023 || NROWS > 511 || NLINES < 2) begin : g_bad
         $error("ccd_frame_readout_sequencer: geometry out of range");
      end
   endgenerate

   state_t state;
   frame_cfg_t cfg;
   logic tick;
   logic half;
   logic pair_open;
   logic [1:0] ph;
   logic [1:0] sum_cnt;
   logic [9:0] col;
   logic [8:0] row;
   logic [EXP_W-1:0] cnt;

   ////////////////////////////////////////////////////////////////////////////
   // single pixel-rate counter feeds every gate clock
   pixel_tick_divider #(.DIV(DIV)) u_div (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .o_tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // line disposition decode for the line being transferred
   wire is_iso = row < ISO_L;
   wire [8:0] img = row - ISO_L;
   wire is_last = (row == ROW_LAST);
   wire keep_skip = cfg.field ? img[0] : ~img[0];
   wire pair_first = (cfg.field ? img[0] : ~img[0]) && !is_last;
   wire go_pair = !pair_open && !is_iso && cfg.mode == MODE_SUM && pair_first;
   wire go_shift = pair_open || (!is_iso && (cfg.mode == MODE_PROG ||
                   (cfg.mode == MODE_SKIP && keep_skip)));
   wire edge_end = tick && half;
   wire pix_end = tick && ph == PH_SIGSAMP;
   wire sum_last = (sum_cnt == cfg.pix_sum);
   wire rows_done = (row == ROW_END);

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: clear, expose, frame transfer, then line by line
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state <= S_IDLE;
         cfg <= '0;
         cnt <= '0;
         half <= 1'b0;
         row <= '0;
         col <= '0;
         ph <= PH_RESET;
         sum_cnt <= '0;
         pair_open <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (i_start) begin
                  cfg <= i_cfg;
                  cnt <= '0;
                  state <= S_CLEAR;
               end
            end
            S_CLEAR: begin
               cnt <= cnt + 1'b1;
               if (cnt == CLEAR_LAST) begin
                  cnt <= '0;
                  state <= S_EXPOSE;
               end
            end
            S_EXPOSE: begin
               cnt <= cnt + 1'b1;
               if (cnt >= cfg.expose_cyc) begin
                  half <= 1'b0;
                  row <= '0;
                  state <= S_FXFER;
               end
            end
            S_FXFER: begin
               if (tick) begin
                  half <= ~half;
               end
               if (edge_end) begin
                  row <= is_last ? '0 : row + 1'b1;
                  if (is_last) begin
                     state <= S_LXFER;
                  end
               end
            end
            S_LXFER: begin
               if (tick) begin
                  half <= ~half;
               end
               if (edge_end) begin
                  row <= row + 1'b1;
                  if (go_pair) begin
                     pair_open <= 1'b1;
                  end else if (go_shift) begin
                     pair_open <= 1'b0;
                     col <= '0;
                     ph <= PH_RESET;
                     sum_cnt <= '0;
                     state <= S_SHIFT;
                  end else begin
                     state <= S_DUMP;
                  end
               end
            end
            S_DUMP: begin
               if (tick) begin
                  half <= ~half;
               end
               if (edge_end) begin
                  state <= rows_done ? S_IDLE : S_LXFER;
               end
            end
            S_SHIFT: begin
               if (tick) begin
                  ph <= ph + 1'b1;
               end
               if (pix_end) begin
                  sum_cnt <= sum_last ? '0 : sum_cnt + 1'b1;
                  col <= col + 1'b1;
                  if (col == COL_LAST) begin
                     state <= rows_done ? S_IDLE : S_LXFER;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate and strobe decode by state and phase; image and storage clocks run together in frame transfer
   wire in_shift = (state == S_SHIFT);
   wire seq_end = rows_done && ((state == S_DUMP && edge_end) ||
                  (in_shift && pix_end && col == COL_LAST));
   gate_bus_t next_gates;
   assign next_gates.image_area_gate_clock = (state == S_FXFER) && half;
   assign next_gates.storage_area_gate_clock = (state == S_FXFER || state == S_LXFER) && half;
   assign next_gates.serial_shift_gate_clock = in_shift && ph == PH_SHIFT;
   assign next_gates.sense_node_reset_gate = in_shift && ph == PH_RESET &&
                                             sum_cnt == 2'h0;
   assign next_gates.line_dump_transfer_gate = (state == S_DUMP) && half;
   assign next_gates.od_clear_pulse = (state == S_CLEAR);
   assign next_gates.od_neg_pulse = (state == S_FXFER);
   wire next_sample_reset = in_shift && tick && ph == PH_REFSAMP && sum_cnt == 2'h0;
   wire next_sample_signal = in_shift && pix_end && sum_last;
   wire next_dark = in_shift && col < DARK_L;
   wire next_line_start = (state == S_LXFER) && edge_end && go_shift;

   // registered outputs
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_gates <= '0;
         o_sample_reset <= 1'b0;
         o_sample_signal <= 1'b0;
         o_dark_ref <= 1'b0;
         o_line_start <= 1'b0;
         o_frame_done <= 1'b0;
         o_busy <= 1'b0;
         o_exposing <= 1'b0;
      end else begin
         o_gates <= next_gates;
         o_sample_reset <= next_sample_reset;
         o_sample_signal <= next_sample_signal;
         o_dark_ref <= next_dark;
         o_line_start <= next_line_start;
         o_frame_done <= seq_end;
         o_busy <= (state != S_IDLE) && !seq_end;
         o_exposing <= (state == S_EXPOSE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks: helper counters for clearing width, transfer and shift counts
   logic [9:0] fx_cnt;
   logic [9:0] ser_cnt;
   logic [EXP_W-1:0] clr_run;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         fx_cnt <= '0;
         ser_cnt <= '0;
         clr_run <= '0;
      end else begin
         // cycles the clearing pulse has stood so far
         clr_run <= o_gates.od_clear_pulse ? clr_run + 1'b1 : '0;
         if (next_gates.image_area_gate_clock && !o_gates.image_area_gate_clock) begin
            fx_cnt <= fx_cnt + 1'b1;
         end else if (state == S_IDLE) begin
            fx_cnt <= '0;
         end
         // cleared while the line transfer stands, so the count survives to its rise
         if (o_gates.storage_area_gate_clock) begin
            ser_cnt <= '0;
         end else if (next_gates.serial_shift_gate_clock &&
                      !o_gates.serial_shift_gate_clock) begin
            ser_cnt <= ser_cnt + 1'b1;
         end
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   a_clear_width: assert property ($fell(o_gates.od_clear_pulse) |-> clr_run >= CLEAR_LEN)
      else $error("clearing pulse shorter than 1 us");
   a_expose_starts: assert property ($fell(o_gates.od_clear_pulse) |-> o_exposing)
      else $error("exposure did not start at end of clearing");
   a_neg_drain: assert property (o_gates.image_area_gate_clock |-> o_gates.od_neg_pulse)
      else $error("no negative drain pulse during transfer");
   a_no_overlap: assert property (o_gates.serial_shift_gate_clock |->
      !(o_gates.storage_area_gate_clock || o_gates.sense_node_reset_gate ||
        o_gates.line_dump_transfer_gate))
      else $error("serial shift overlaps another gate");
   a_reset_then_shift: assert property ($rose(o_gates.sense_node_reset_gate) |->
      ##[1:64] $rose(o_gates.serial_shift_gate_clock))
      else $error("node reset not followed by serial shift");
   a_sum_reset: assert property (o_gates.sense_node_reset_gate |-> $past(sum_cnt) == 2'h0)
      else $error("node reset inside a summing group");
   a_frame_rows: assert property ($fell(o_gates.od_neg_pulse) |-> fx_cnt == 10'(NROWS))
      else $error("frame transfer shift count wrong");
   a_line_cols: assert property ($rose(o_gates.storage_area_gate_clock) && !o_gates.od_neg_pulse
      |-> ser_cnt == 10'h0 || ser_cnt == 10'(NCOLS))
      else $error("line not fully shifted before next transfer");
   a_dark_ref: assert property (o_sample_signal |-> o_dark_ref == ($past(col) < DARK_L))
      else $error("dark reference flag wrong");

   c_frame_done: cover property (o_frame_done);
   c_dump: cover property ($rose(o_gates.line_dump_transfer_gate));
   c_pair: cover property (pair_open && state == S_SHIFT);
   c_pix_sum: cover property (o_sample_signal && cfg.pix_sum != 2'h0);
endmodule

// File: ccd_readout_pkg.sv
// shared constants and types for the ccd readout controller, plus its pixel-rate divider
package ccd_readout_pkg;
   localparam int LINES = 488; // image lines per frame
   localparam int COLS = 780; // elements per line
   localparam int DARK_COLS = 26; // shielded columns at left edge
   localparam int ISO_LINES = 4; // dark isolation lines
   localparam int ROWS = LINES + ISO_LINES; // parallel shifts per frame transfer
   localparam int CLK_HZ = 10_000_000; // i_mclk rate
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ; // clock period in ns
   localparam int CLEAR_NS = 1000; // least clearing pulse width, ns
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS; // rounded up
   localparam int PIX_DIV = 2; // clock cycles per pixel-rate tick
   localparam int EXP_W = 24; // exposure counter width
   localparam logic [1:0] PH_RESET = 2'h0; // node reset phase
   localparam logic [1:0] PH_REFSAMP = 2'h1; // reset level sample phase
   localparam logic [1:0] PH_SHIFT = 2'h2; // serial shift phase
   localparam logic [1:0] PH_SIGSAMP = 2'h3; // signal level sample phase

   typedef enum logic [1:0] {
      MODE_PROG = 2'h0,
      MODE_SUM = 2'h1,
      MODE_SKIP = 2'h2
   } scan_mode_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_CLEAR = 7'h02,
      S_EXPOSE = 7'h04,
      S_FXFER = 7'h08,
      S_LXFER = 7'h10,
      S_DUMP = 7'h20,
      S_SHIFT = 7'h40
   } state_t;

   typedef struct packed {
      logic image_area_gate_clock;
      logic storage_area_gate_clock;
      logic serial_shift_gate_clock;
      logic sense_node_reset_gate;
      logic line_dump_transfer_gate;
      logic od_clear_pulse; // overflow_drain_bias raised for clearing
      logic od_neg_pulse; // overflow_drain_bias lowered during transfer
   } gate_bus_t;

   typedef struct packed {
      scan_mode_t mode;
      logic field; // 0: lines 1+2 / odd kept, 1: lines 2+3 / even kept
      logic [1:0] pix_sum; // elements summed on the node, minus one
      logic [EXP_W-1:0] expose_cyc; // integration time in clock cycles
   } frame_cfg_t;
endpackage

////////////////////////////////////////////////////////////////////////////////
module pixel_tick_divider import ccd_readout_pkg::*; #(
   parameter int DIV = PIX_DIV
) (
   input wire logic i_mclk, // system clock
   input wire logic i_resetn, // sync reset, active low
   output logic o_tick // one-cycle pixel-rate enable
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt;

   generate
      if (DIV < 1) begin : g_bad
         $error("pixel_tick_divider: DIV must be at least 1");
      end
   endgenerate

   // free-running divide counter
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
         o_tick <= (cnt == LAST);
      end
   end
endmodule

// File: ccd_device_model.sv
// behavioural model of the frame-transfer sensor, counting what the gates do to its charge
module ccd_device_model import ccd_readout_pkg::*; #(
   parameter int NCOLS = COLS // elements per line
) (
   input wire logic i_mclk, // system clock
   input wire gate_bus_t i_gates, // gate clocks and drain pulses
   input wire logic i_clear, // zero all counters
   output int o_n_xfer, // frame transfer shifts
   output int o_n_ltr, // lines moved into serial register
   output int o_n_dump, // lines dumped to clearing drain
   output int o_n_shift, // serial shifts
   output int o_n_rst, // node resets
   output int o_int_cyc, // integration time in cycles
   output logic o_fault // illegal gate use seen
);
   gate_bus_t prev = '0;
   int col = 0;
   int held = 0;
   logic integ = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // rising edges of each gate act on the charge
   always @(posedge i_mclk) begin
      if (i_clear) begin
         {o_n_xfer, o_n_ltr, o_n_dump, o_n_shift, o_n_rst, o_int_cyc} = '0;
         o_fault = 1'b0;
         col = 0;
         held = 0;
         integ = 1'b0;
      end else begin
         // clearing empties the wells, its end starts integration
         if (i_gates.od_clear_pulse) begin
            integ = 1'b1;
            o_int_cyc = 0;
         end else if (integ) begin
            o_int_cyc++;
         end
         // parallel shift moves the image and isolation rows to storage
         if (i_gates.image_area_gate_clock && !prev.image_area_gate_clock) begin
            o_n_xfer++;
            integ = 1'b0;
            if (!i_gates.od_neg_pulse) o_fault = 1'b1;
         end
         // one stored line into the serial register, two fit at most
         if (i_gates.storage_area_gate_clock && !prev.storage_area_gate_clock
             && !i_gates.od_neg_pulse) begin
            o_n_ltr++;
            held++;
            if (held > 2) o_fault = 1'b1;
         end
         // dump gate sends the held charge to the clearing drain
         if (i_gates.line_dump_transfer_gate && !prev.line_dump_transfer_gate) begin
            o_n_dump++;
            held = 0;
            col = 0;
         end
         // serial shift; register is empty after a whole line
         if (i_gates.serial_shift_gate_clock && !prev.serial_shift_gate_clock) begin
            o_n_shift++;
            col++;
            if (col == NCOLS) begin
               col = 0;
               held = 0;
            end
         end
         if (i_gates.sense_node_reset_gate && !prev.sense_node_reset_gate) o_n_rst++;
         // shift never together with node reset or line transfer
         if (i_gates.serial_shift_gate_clock && (i_gates.sense_node_reset_gate
             || i_gates.storage_area_gate_clock)) o_fault = 1'b1;
      end
      prev = i_gates;
   end
endmodule

// File: tb_top.sv
// self-checking testbench of the readout sequencer against the sensor model
module tb_top;
   import ccd_readout_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NC = 30;
   localparam int NL = 4;
   localparam int EXP = 20;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_start = 1'b0;
   logic clr = 1'b0;
   frame_cfg_t i_cfg = '0;
   gate_bus_t gates;
   logic s_rst, s_sig, dark, lst, done, busy, expo, flt;
   int n_fail = 0;
   int n_compared = 0;
   int n_clr, n_exp, n_sig, n_ref, n_dark, n_lst, nx, nl, nd, ns, nr, ni;

   always #50 i_mclk = ~i_mclk;

   ccd_frame_readout_sequencer #(.NCOLS(NC), .NLINES(NL), .DIV(PIX_DIV)) i_dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(i_start), .i_cfg(i_cfg),
      .o_gates(gates), .o_sample_reset(s_rst), .o_sample_signal(s_sig), .o_dark_ref(dark),
      .o_line_start(lst), .o_frame_done(done), .o_busy(busy), .o_exposing(expo));

   ccd_device_model #(.NCOLS(NC)) i_model (
      .i_mclk(i_mclk), .i_gates(gates), .i_clear(clr), .o_n_xfer(nx), .o_n_ltr(nl),
      .o_n_dump(nd), .o_n_shift(ns), .o_n_rst(nr), .o_int_cyc(ni), .o_fault(flt));

   ////////////////////////////////////////////////////////////////////////////
   // counts of pulses and levels per frame
   always @(posedge i_mclk) begin
      if (clr) begin
         {n_clr, n_exp, n_sig, n_ref, n_dark, n_lst} <= '0;
      end else begin
         n_clr <= n_clr + gates.od_clear_pulse;
         n_exp <= n_exp + expo;
         n_sig <= n_sig + s_sig;
         n_ref <= n_ref + s_rst;
         n_dark <= n_dark + (s_sig && dark);
         n_lst <= n_lst + lst;
      end
   end

   task check(input string w, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", w, exp, seen);
      end
   endtask

   // one frame; stray asks a refused start while busy
   task run_frame(input scan_mode_t m, input logic f, input logic [1:0] ps, input int rd,
                  input int dmp, input bit stray);
      int k;
      int grp;
      grp = NC / (ps + 1);
      @(posedge i_mclk) begin
         clr <= 1'b1;
         i_start <= 1'b1;
         i_cfg <= '{m, f, ps, 24'(EXP)};
      end
      @(posedge i_mclk) begin
         clr <= 1'b0;
         i_start <= 1'b0;
      end
      // start taken at this edge; the drain pulse shows one edge later
      #1 check("clear early", gates.od_clear_pulse, 1'b0);
      @(posedge i_mclk) #1 check("clear rise", gates.od_clear_pulse, 1'b1);
      check("busy in frame", busy, 1'b1);
      if (stray) begin
         @(posedge i_mclk) begin
            i_start <= 1'b1;
            i_cfg <= '{MODE_SKIP, 1'b1, 2'h0, 24'h000005};
         end
         @(posedge i_mclk) i_start <= 1'b0;
      end
      for (k = 0; k < 20000 && done !== 1'b1; k++) @(posedge i_mclk) #1;
      check("frame done", done, 1'b1);
      check("busy at end", busy, 1'b0);
      // the last signal sample stands with done and is counted one edge later
      @(posedge i_mclk) #1;
      check("clear width", n_clr, CLEAR_CYC);
      check("expose length", n_exp, EXP + 1);
      check("integration", ni >= EXP, 1'b1);
      check("frame shifts", nx, NL + ISO_LINES);
      check("line transfers", nl, NL + ISO_LINES);
      check("dumped lines", nd, dmp);
      check("lines read", n_lst, rd);
      check("serial shifts", ns, NC * rd);
      check("node resets", nr, grp * rd);
      check("reference samples", n_ref, grp * rd);
      check("signal samples", n_sig, grp * rd);
      if (ps == 2'h0) check("dark samples", n_dark, DARK_COLS * rd);
      check("model fault", flt, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_prog;
      run_frame(MODE_PROG, 1'b0, 2'h0, NL, ISO_LINES, 1'b0);
   endtask

   task t_skip;
      run_frame(MODE_SKIP, 1'b0, 2'h0, NL / 2, ISO_LINES + NL / 2, 1'b0);
      run_frame(MODE_SKIP, 1'b1, 2'h0, NL / 2, ISO_LINES + NL / 2, 1'b0);
   endtask

   task t_sum;
      run_frame(MODE_SUM, 1'b0, 2'h0, NL / 2, ISO_LINES, 1'b0);
      run_frame(MODE_SUM, 1'b1, 2'h0, NL / 2 - 1, ISO_LINES + 2, 1'b0);
   endtask

   task t_pixsum;
      run_frame(MODE_PROG, 1'b1, 2'h2, NL, ISO_LINES, 1'b1);
   endtask

   task stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence: reset, then frames back to back
   initial begin
      repeat (5) @(posedge i_mclk);
      i_resetn <= 1'b1;
      t_prog;
      t_skip;
      t_sum;
      t_pixsum;
      stop_test;
   end

   // watchdog against a hung sequence
   initial begin
      repeat (40000) @(posedge i_mclk);
      n_fail++;
      stop_test;
   end
endmodule
